// ---- cskda_defs.svh ----
// Offsets, field positions, reset values and timing counts of the compare/skip/adjust unit
`ifndef CSKDA_DEFS_SVH
`define CSKDA_DEFS_SVH
`define CSKDA_CLK_NS      10
`define CSKDA_QCYC_NS     40
`define CSKDA_QPH         (`CSKDA_QCYC_NS / `CSKDA_CLK_NS)
`define CSKDA_OFS_CTRL    5'h00
`define CSKDA_OFS_BANK    5'h04
`define CSKDA_OFS_ACC     5'h08
`define CSKDA_OFS_FLAGS   5'h0C
`define CSKDA_OFS_STATE   5'h10
`define CSKDA_CTRL_EXT    0
`define CSKDA_FLG_C       0
`define CSKDA_FLG_HC      1
`define CSKDA_ENC_CLT     7'h30
`define CSKDA_ENC_CEQ     7'h31
`define CSKDA_ENC_CGT     7'h32
`define CSKDA_ENC_DADJ    16'h0007
`define CSKDA_ILO_LIMIT   8'h5F
`define CSKDA_BCD_MAX     4'h9
`define CSKDA_BCD_ADJ     4'h6
`define CSKDA_RST_ACC     8'h00
`define CSKDA_RST_BANK    4'h0
`endif

// ---- cskda_pkg.sv ----
// Types shared by the compare/skip/adjust unit
package cskda_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_EXEC  = 2'h1,
        ST_SKIP1 = 2'h3,
        ST_SKIP2 = 2'h2
    } cskda_state_e;
    typedef enum logic [2:0] {
        OP_NONE, OP_CLT, OP_CEQ, OP_CGT, OP_DADJ
    } cskda_op_e;
    typedef struct packed {
        logic        valid;
        logic        next_two_word;
        logic [15:0] word;
    } cskda_instr_s;
    typedef struct packed {
        logic        rd;
        logic [11:0] addr;
    } cskda_mem_s;
endpackage : cskda_pkg

// ---- cskda_core.sv ----
// Compare-and-skip and decimal adjust execution unit with Avalon-MM registers
`include "cskda_defs.svh"

// Operation
// RQ1: Word with upper byte 0110010a decodes as compare_greater_skip, low byte the address.
// RQ2: Word with upper byte 0110000a decodes as compare_less_skip, low byte the address.
// RQ3: compare_greater_skip skips the next instruction when register exceeds accumulator.
// RQ4: compare_less_skip skips the next instruction when register is below accumulator.
// RQ5: Compare-skip takes one cycle, two on a skip, three when skipping a two-word one.
// RQ6: First cycle decodes, reads in phase two, processes, writes nothing; skip cycles idle.
// RQ7: Compare-skip leaves every status flag untouched.
// RQ8: Bank bit clear selects the access bank, set uses the bank_select_pointer.
// RQ9: Extended set, bank bit clear and address up to 95 use indexed literal offset.
// RQ10: Decimal adjust adds 6 to the low nibble when above 9 or half_carry_flag set.
// RQ11: Decimal adjust adds 6 to the high nibble and sets carry when above 9 or carry set.
// RQ12: Decimal adjust is one cycle: read phase two, process phase three, write phase four.
// RQ13: Word with upper byte 0110001a decodes as compare_equal_skip, low byte the address.
// RQ14: compare_equal_skip skips the next instruction when register equals accumulator.
module cskda_core #(
    parameter logic [7:0] ACCESS_SPLIT = 8'h80
) (
    input  wire logic                ref_clk_in,
    input  wire logic                rst_in,
    input  wire logic [4:0]          avs_address_in,
    input  wire logic                avs_read_in,
    input  wire logic                avs_write_in,
    input  wire logic [31:0]         avs_writedata_in,
    output logic      [31:0]         avs_readdata_out,
    output logic                     avs_waitrequest_out,
    input  wire cskda_pkg::cskda_instr_s instr_in,
    output logic                     instr_ready_out,
    output logic                     flush_out,
    output cskda_pkg::cskda_mem_s    mem_req_out,
    input  wire logic [7:0]          mem_rdata_in,
    input  wire logic [11:0]         index_base_in,
    output logic      [7:0]          accumulator_out
);
    import cskda_pkg::*;

    localparam logic [1:0] Q_LAST = 2'(`CSKDA_QPH - 1);

    cskda_state_e state_r, state_nxt;
    cskda_op_e    op_r, op_nxt;
    logic [1:0]   q_r, q_nxt;
    logic         bank_bit_r, bank_bit_nxt;
    logic [7:0]   faddr_r, faddr_nxt;
    logic [7:0]   data_r, data_nxt;
    logic         two_r, two_nxt;
    logic         skip_r, skip_nxt;
    logic [7:0]   acc_r, acc_nxt;
    logic         c_r, c_nxt;
    logic         hc_r, hc_nxt;
    logic         ext_r, ext_nxt;
    logic [3:0]   bank_r, bank_nxt;
    logic         ack_r, ack_nxt;
    logic [31:0]  rdata_r, rdata_nxt;

    logic         take;
    logic         bus_req;
    logic         bus_wr;
    logic [8:0]   adj_lo;
    logic [8:0]   adj_hi;
    logic         lo_fix;
    logic         hi_fix;
    logic         hit;
    cskda_op_e    dec_op;

    function automatic cskda_op_e decode(input logic [15:0] w);
        cskda_op_e o;
        o = OP_NONE;
        case (w[15:9])
            `CSKDA_ENC_CGT: o = OP_CGT; // RQ1
            `CSKDA_ENC_CLT: o = OP_CLT; // RQ2
            `CSKDA_ENC_CEQ: o = OP_CEQ; // RQ13
            default: begin
                if (w == `CSKDA_ENC_DADJ) begin
                    o = OP_DADJ;
                end
            end
        endcase
        return o;
    endfunction : decode

    // New work is only taken at the start of an instruction cycle
    assign instr_ready_out = (state_r == ST_IDLE) && (q_r == 2'h0);
    assign dec_op          = decode(instr_in.word);
    assign take            = instr_ready_out && instr_in.valid && (dec_op != OP_NONE);
    assign flush_out       = (state_r == ST_SKIP1) || (state_r == ST_SKIP2);
    assign accumulator_out = acc_r;
    assign bus_req         = avs_read_in || avs_write_in;
    assign bus_wr          = avs_write_in && ack_r;
    assign avs_waitrequest_out = bus_req && !ack_r;
    assign avs_readdata_out    = rdata_r;

    always_comb begin
        mem_req_out.rd   = (state_r == ST_EXEC) && (q_r == 2'h1)
                           && (op_r != OP_DADJ); // RQ6
        mem_req_out.addr = {bank_r, faddr_r}; // RQ8
        if (!bank_bit_r && ext_r && (faddr_r <= `CSKDA_ILO_LIMIT)) begin
            mem_req_out.addr = 12'(index_base_in + {4'h0, faddr_r}); // RQ9
        end else if (!bank_bit_r) begin
            mem_req_out.addr = (faddr_r < ACCESS_SPLIT) ? {4'h0, faddr_r}
                                                        : {4'hF, faddr_r}; // RQ8
        end
    end

    // Half-carry out of the low fix must reach the high nibble
    always_comb begin
        lo_fix = (acc_r[3:0] > `CSKDA_BCD_MAX) || hc_r; // RQ10
        adj_lo = {1'b0, acc_r} + (lo_fix ? {5'h0, `CSKDA_BCD_ADJ} : 9'h000);
        hi_fix = (adj_lo[7:4] > `CSKDA_BCD_MAX) || c_r || adj_lo[8]; // RQ11
        adj_hi = {1'b0, adj_lo[7:0]} + (hi_fix ? {1'b0, `CSKDA_BCD_ADJ, 4'h0} : 9'h000);
    end

    always_comb begin
        case (op_r)
            OP_CGT: hit = data_r > acc_r; // RQ3
            OP_CLT: hit = data_r < acc_r; // RQ4
            OP_CEQ: hit = data_r == acc_r; // RQ14
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        state_nxt    = state_r;
        op_nxt       = op_r;
        q_nxt        = (q_r == Q_LAST) ? 2'h0 : 2'(q_r + 2'h1);
        bank_bit_nxt = bank_bit_r;
        faddr_nxt    = faddr_r;
        data_nxt     = data_r;
        two_nxt      = two_r;
        skip_nxt     = skip_r;
        acc_nxt      = acc_r;
        c_nxt        = c_r;
        hc_nxt       = hc_r;
        case (state_r)
            ST_IDLE: begin
                if (take) begin
                    state_nxt    = ST_EXEC;
                    op_nxt       = dec_op;
                    bank_bit_nxt = instr_in.word[8];
                    faddr_nxt    = instr_in.word[7:0];
                    two_nxt      = instr_in.next_two_word;
                end
            end
            ST_EXEC: begin
                if (q_r == 2'h1) begin
                    data_nxt = (op_r == OP_DADJ) ? acc_r : mem_rdata_in; // RQ12
                end
                if (q_r == 2'h2) begin
                    skip_nxt = hit; // RQ6
                end
                if (q_r == Q_LAST) begin
                    if (op_r == OP_DADJ) begin // RQ7
                        acc_nxt = adj_hi[7:0]; // RQ12
                        c_nxt   = hi_fix; // RQ11
                    end
                    state_nxt = skip_r ? ST_SKIP1 : ST_IDLE; // RQ5
                end
            end
            ST_SKIP1: begin
                if (q_r == Q_LAST) begin
                    state_nxt = two_r ? ST_SKIP2 : ST_IDLE; // RQ5
                end
            end
            ST_SKIP2: begin
                if (q_r == Q_LAST) begin
                    state_nxt = ST_IDLE; // RQ5
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        // Accumulator and flag writes yield to an adjust result landing in the same cycle
        if (bus_wr && !(state_r == ST_EXEC && q_r == Q_LAST && op_r == OP_DADJ)) begin
            if (avs_address_in == `CSKDA_OFS_ACC) begin
                acc_nxt = avs_writedata_in[7:0];
            end
            if (avs_address_in == `CSKDA_OFS_FLAGS) begin
                c_nxt  = avs_writedata_in[`CSKDA_FLG_C];
                hc_nxt = avs_writedata_in[`CSKDA_FLG_HC];
            end
        end
    end

    always_comb begin
        ack_nxt   = bus_req && !ack_r;
        rdata_nxt = rdata_r;
        ext_nxt   = ext_r;
        bank_nxt  = bank_r;
        if (ack_nxt) begin
            case (avs_address_in)
                `CSKDA_OFS_CTRL:  rdata_nxt = {31'h0, ext_r};
                `CSKDA_OFS_BANK:  rdata_nxt = {28'h0, bank_r};
                `CSKDA_OFS_ACC:   rdata_nxt = {24'h0, acc_r};
                `CSKDA_OFS_FLAGS: rdata_nxt = {30'h0, hc_r, c_r};
                `CSKDA_OFS_STATE: rdata_nxt = {25'h0, skip_r, op_r, state_r, 1'b0};
                default:          rdata_nxt = 32'h0;
            endcase
        end
        if (bus_wr && avs_address_in == `CSKDA_OFS_CTRL) begin
            ext_nxt = avs_writedata_in[`CSKDA_CTRL_EXT];
        end
        if (bus_wr && avs_address_in == `CSKDA_OFS_BANK) begin
            bank_nxt = avs_writedata_in[3:0];
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r    <= ST_IDLE;
            op_r       <= OP_NONE;
            q_r        <= 2'h0;
            bank_bit_r <= 1'b0;
            faddr_r    <= 8'h00;
            data_r     <= 8'h00;
            two_r      <= 1'b0;
            skip_r     <= 1'b0;
            acc_r      <= `CSKDA_RST_ACC;
            c_r        <= 1'b0;
            hc_r       <= 1'b0;
            ext_r      <= 1'b0;
            bank_r     <= `CSKDA_RST_BANK;
            ack_r      <= 1'b0;
            rdata_r    <= 32'h0;
        end else begin
            state_r    <= state_nxt;
            op_r       <= op_nxt;
            q_r        <= q_nxt;
            bank_bit_r <= bank_bit_nxt;
            faddr_r    <= faddr_nxt;
            data_r     <= data_nxt;
            two_r      <= two_nxt;
            skip_r     <= skip_nxt;
            acc_r      <= acc_nxt;
            c_r        <= c_nxt;
            hc_r       <= hc_nxt;
            ext_r      <= ext_nxt;
            bank_r     <= bank_nxt;
            ack_r      <= ack_nxt;
            rdata_r    <= rdata_nxt;
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    logic is_cmp;
    assign is_cmp = (op_r == OP_CGT) || (op_r == OP_CLT) || (op_r == OP_CEQ);

    sequence exec_end_s;
        state_r == ST_EXEC && q_r == Q_LAST;
    endsequence

    sequence skip_run_s;
        state_r == ST_SKIP1 [*4];
    endsequence

    gt_decode_a: assert property ( // RQ1
        take && instr_in.word[15:9] == 7'h32 |=> op_r == OP_CGT && state_r == ST_EXEC)
        else $error("greater compare not decoded");
    lt_decode_a: assert property ( // RQ2
        take && instr_in.word[15:9] == 7'h30 |=> op_r == OP_CLT && faddr_r == $past(instr_in.word[7:0]))
        else $error("less compare not decoded");
    eq_decode_a: assert property ( // RQ13
        take && instr_in.word[15:9] == 7'h31 |=> op_r == OP_CEQ)
        else $error("equal compare not decoded");
    gt_skip_a: assert property ( // RQ3
        exec_end_s and op_r == OP_CGT |-> (data_r > acc_r) == skip_r)
        else $error("greater skip decision wrong");
    lt_skip_a: assert property ( // RQ4
        exec_end_s and op_r == OP_CLT |-> (data_r < acc_r) == skip_r)
        else $error("less skip decision wrong");
    eq_skip_a: assert property ( // RQ14
        exec_end_s and op_r == OP_CEQ |-> (data_r == acc_r) == skip_r)
        else $error("equal skip decision wrong");
    skip_len_a: assert property ( // RQ5
        exec_end_s and skip_r && !two_r |=> skip_run_s ##1 state_r == ST_IDLE)
        else $error("one-word skip length wrong");
    skip_two_a: assert property ( // RQ5
        exec_end_s and skip_r && two_r |=> skip_run_s ##1 state_r == ST_SKIP2 [*4] ##1 !flush_out)
        else $error("two-word skip length wrong");
    cmp_quiet_a: assert property ( // RQ7
        state_r == ST_EXEC && is_cmp |=> $stable(c_r) && $stable(hc_r) && $stable(acc_r))
        else $error("compare changed flags");
    bank_use_a: assert property ( // RQ8
        mem_req_out.rd && bank_bit_r |-> mem_req_out.addr[11:8] == bank_r)
        else $error("bank pointer not used");
    ilo_addr_a: assert property ( // RQ9
        mem_req_out.rd && !bank_bit_r && ext_r && faddr_r <= 8'h5F
        |-> mem_req_out.addr == 12'(index_base_in + {4'h0, faddr_r}))
        else $error("indexed offset address wrong");
    read_phase_a: assert property ( // RQ6
        mem_req_out.rd |-> q_r == 2'h1 && !flush_out)
        else $error("register read outside phase two");
    adj_low_a: assert property ( // RQ10
        exec_end_s and op_r == OP_DADJ && !bus_wr && acc_r[3:0] < 4'hA && !hc_r && !c_r
        && acc_r[7:4] < 4'hA |=> acc_r == $past(acc_r) && !c_r)
        else $error("adjust changed valid digits");
    adj_carry_a: assert property ( // RQ11
        exec_end_s and op_r == OP_DADJ && c_r |=> c_r && acc_r[7:4] != $past(acc_r[7:4]))
        else $error("adjust high digit not fixed");
endmodule : cskda_core

// ---- cskda_mem_model.sv ----
// Banked data memory partner that answers compare reads
module cskda_mem_model (
    input  wire logic                  ref_clk_in,
    input  wire cskda_pkg::cskda_mem_s req_in,
    output logic      [7:0]            rdata_out,
    output logic      [11:0]           last_addr_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import cskda_pkg::*;
    logic [7:0] cells [4096];
    logic [7:0] last_r = 8'hA5;
    // Outside a read the bus shows the inverse of the last data, so stale data never matches
    assign rdata_out = req_in.rd ? cells[req_in.addr] : ~last_r;
    always_ff @(posedge ref_clk_in) begin
        if (req_in.rd) begin
            last_r        <= cells[req_in.addr];
            last_addr_out <= req_in.addr;
        end
    end
    task automatic load(input logic [11:0] a, input logic [7:0] v);
        cells[a] = v;
    endtask : load
endmodule : cskda_mem_model

// ---- tb_compare_skip_decimal_adjust.sv ----
// Self-checking bench for the compare/skip/adjust unit
`include "cskda_defs.svh"
module tb_compare_skip_decimal_adjust;
    timeunit 1ns;
    timeprecision 1ps;
    import cskda_pkg::*;
    logic         ref_clk_in, rst_in, rd, wr, wreq, rdy, flush;
    logic [4:0]   adr;
    logic [31:0]  wd, rdata;
    cskda_instr_s ins;
    cskda_mem_s   mreq;
    logic [7:0]   mrd, acc;
    logic [11:0]  base, laddr;
    logic [31:0]  exp_q[$], msk_q[$], fl_q[$];
    int           fail_count = 0, compares = 0, fl_cnt = 0, cyc = 0;
    logic [31:0]  seed = 32'd51979;
    logic [6:0]   encs [3] = '{`CSKDA_ENC_CLT, `CSKDA_ENC_CEQ, `CSKDA_ENC_CGT};

    cskda_core DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .avs_address_in(adr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .instr_in(ins),
        .instr_ready_out(rdy), .flush_out(flush), .mem_req_out(mreq),
        .mem_rdata_in(mrd), .index_base_in(base), .accumulator_out(acc));
    cskda_mem_model MEM (.ref_clk_in(ref_clk_in), .req_in(mreq), .rdata_out(mrd),
        .last_addr_out(laddr));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    // Request held until waitrequest is sampled low at a rising edge, released at that edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge ref_clk_in); while (wreq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic rdx(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask : rdx

    task automatic issue(input logic [15:0] w, input logic two);
        @(posedge ref_clk_in);
        ins <= '{valid: 1'b1, next_two_word: two, word: w};
        do @(posedge ref_clk_in); while (rdy !== 1'b1);
        ins.valid <= 1'b0;
        do @(posedge ref_clk_in); while (rdy !== 1'b1);
    endtask : issue

    always @(posedge ref_clk_in) begin : mon
        logic [31:0] m;
        if (rd && wreq === 1'b0) begin
            m = msk_q.pop_front();
            check(rdata & m, exp_q.pop_front() & m);
        end
        if (flush === 1'b1) fl_cnt++;
        else if (fl_cnt != 0) begin
            check(32'(fl_cnt), fl_q.pop_front());
            fl_cnt = 0;
        end
    end

    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            report_and_stop();
        end
    end

    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    initial begin : main
        logic [31:0] r, r2;
        logic [7:0]  f, av, rv;
        logic [11:0] ea;
        logic [8:0]  t;
        logic [1:0]  k, fl;
        logic        skip;
        rst_in = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        adr = 5'h00;
        wd = 32'h0;
        ins = '0;
        base = 12'h000;
        repeat (12) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        rdx(`CSKDA_OFS_ACC, 32'h0, 32'hFF);
        rdx(5'h14, 32'h0, 32'hFFFFFFFF);
        for (int i = 0; i < 48; i++) begin
            r = rnd();
            r2 = rnd();
            k = (r[1:0] == 2'h3) ? 2'h1 : r[1:0];
            f = (i < 4) ? 8'h5F + 8'(i[0]) : r[9:2];
            av = r[24:17];
            rv = r2[0] ? av : (r2[1] ? av + 8'h01 : r2[8:1]);
            fl = r2[10:9];
            base <= r2[22:11];
            bus(1'b1, `CSKDA_OFS_CTRL, {31'h0, r[11] | (i < 4)});
            bus(1'b1, `CSKDA_OFS_BANK, {28'h0, r[16:13]});
            bus(1'b1, `CSKDA_OFS_ACC, {24'h0, av});
            bus(1'b1, `CSKDA_OFS_FLAGS, {30'h0, fl});
            if (!r[10] && (r[11] || i < 4) && f <= `CSKDA_ILO_LIMIT) ea = r2[22:11] + 12'(f);
            else if (!r[10]) ea = (f < 8'h80) ? {4'h0, f} : {4'hF, f};
            else ea = {r[16:13], f};
            MEM.load(ea, rv);
            skip = (k == 2'h0) ? rv < av : (k == 2'h1) ? rv == av : rv > av;
            if (skip) fl_q.push_back(r[12] ? 32'd8 : 32'd4);
            issue({encs[k], r[10], f}, r[12]);
            check({20'h0, laddr}, {20'h0, ea});
            check({24'h0, acc}, {24'h0, av});
            rdx(`CSKDA_OFS_STATE, {25'h0, skip, 6'h0}, 32'h40);
            rdx(`CSKDA_OFS_ACC, {24'h0, av}, 32'hFF);
            rdx(`CSKDA_OFS_FLAGS, {30'h0, fl}, 32'h3);
        end
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            av = (i == 0) ? 8'hA5 : (i == 1) ? 8'hCE : r[7:0];
            fl = (i < 2) ? 2'h0 : r[9:8];
            bus(1'b1, `CSKDA_OFS_ACC, {24'h0, av});
            bus(1'b1, `CSKDA_OFS_FLAGS, {30'h0, fl});
            issue(`CSKDA_ENC_DADJ, 1'b0);
            t = {1'b0, av};
            if (av[3:0] > 4'h9 || fl[1]) t = t + 9'h006;
            if (t[7:4] > 4'h9 || fl[0] || t[8]) t = {1'b1, t[7:0] + 8'h60};
            else t[8] = 1'b0;
            check({24'h0, acc}, {24'h0, t[7:0]});
            rdx(`CSKDA_OFS_ACC, {24'h0, t[7:0]}, 32'hFF);
            rdx(`CSKDA_OFS_FLAGS, {30'h0, fl[1], t[8]}, 32'h3);
        end
        check(32'(fl_q.size()), 32'h0);
        report_and_stop();
    end
endmodule : tb_compare_skip_decimal_adjust
